// ===== rtl/pjl_core.sv
// Sequencer for the page jump and logical AND slice of the core.
// Assumes code, register, data and bit stores answer one cycle after a read strobe
// and hold their read data while clk_en is low.
`default_nettype none

module pjl_core
  import pjl_pkg::*;
#(
  parameter int PC_W = 16
)
(
  // Clock, reset, enable
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  // Code fetch
  output logic                  code_rd,
  output logic [PC_W-1:0]       code_addr,
  input  wire logic [7:0]       code_data,
  // Working registers
  output logic                  reg_rd,
  output logic [2:0]            reg_sel,
  input  wire logic [7:0]       reg_rdata,
  // Internal data memory
  output logic                  dmem_rd,
  output logic                  dmem_wr,
  output logic [7:0]            dmem_addr,
  output logic [7:0]            dmem_wdata,
  input  wire logic [7:0]       dmem_rdata,
  // Bit space
  output logic                  bit_rd,
  output logic [7:0]            bit_addr,
  input  wire logic             bit_rdata,
  // Architectural state
  output logic [PC_W-1:0]       pc,
  output logic [7:0]            acc,
  output logic                  carry,
  // Retire report
  output logic                  instr_done,
  output logic [1:0]            instr_bytes,
  output logic [1:0]            instr_cycles,
  output logic                  instr_unknown
);

  typedef struct packed {
    pjl_fsm_type     st;
    logic [PC_W-1:0] pc;
    logic [7:0]      acc;
    logic            cy;
    logic [7:0]      op;
    logic [7:0]      b2;
    logic [7:0]      b3;
    logic            code_rd;
    logic [PC_W-1:0] code_addr;
    logic            reg_rd;
    logic [2:0]      reg_sel;
    logic            dmem_rd;
    logic            dmem_wr;
    logic [7:0]      dmem_addr;
    logic [7:0]      dmem_wdata;
    logic            bit_rd;
    logic [7:0]      bit_addr;
    logic            done;
    logic [1:0]      done_bytes;
    logic [1:0]      done_cycles;
    logic            unknown;
  } pjl_state_type;

  pjl_state_type   r;
  pjl_state_type   r_nxt;
  pjl_class_type   cls;
  logic [1:0]      nbytes;
  logic [1:0]      ncycles;
  logic [7:0]      acc_res;
  logic            carry_res;
  logic [7:0]      mem_res;
  logic [PC_W-1:0] jump_pc;

  // ****************************************
  // Decode and result logic
  // ****************************************
  pjl_decode u_decode (
    .opcode    (r.op),
    .op_class  (cls),
    .op_bytes  (nbytes),
    .op_cycles (ncycles)
  );

  pjl_logic #(.PC_W(PC_W)) u_logic (
    .op_class   (cls),
    .opcode     (r.op),
    .byte2      (r.b2),
    .byte3      (r.b3),
    .pc         (r.pc),
    .acc        (r.acc),
    .carry      (r.cy),
    .reg_rdata  (reg_rdata),
    .dmem_rdata (dmem_rdata),
    .bit_rdata  (bit_rdata),
    .acc_res    (acc_res),
    .carry_res  (carry_res),
    .mem_res    (mem_res),
    .jump_pc    (jump_pc)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    r_nxt         = r;
    // Strobes, done and unknown last one cycle; done_bytes and done_cycles hold until the next retire
    r_nxt.code_rd = 1'b0;
    r_nxt.reg_rd  = 1'b0;
    r_nxt.dmem_rd = 1'b0;
    r_nxt.dmem_wr = 1'b0;
    r_nxt.bit_rd  = 1'b0;
    r_nxt.done    = 1'b0;
    r_nxt.unknown = 1'b0;
    unique case (r.st)
      S_FETCH: begin
        r_nxt.code_rd   = 1'b1;
        r_nxt.code_addr = r.pc;
        r_nxt.st        = S_OPC_WAIT;
      end
      S_OPC_WAIT: r_nxt.st = S_OPC;
      S_OPC: begin
        r_nxt.op = code_data;
        r_nxt.pc = r.pc + 1'b1;
        r_nxt.st = S_OPER;
        if (pjl_decode_bytes(code_data) != BYTES_ONE) begin
          r_nxt.code_rd   = 1'b1;
          r_nxt.code_addr = r.pc + 1'b1;
          r_nxt.st        = S_B2_WAIT;
        end
      end
      S_B2_WAIT: r_nxt.st = S_B2;
      S_B2: begin
        r_nxt.b2 = code_data;
        r_nxt.pc = r.pc + 1'b1;
        r_nxt.st = S_OPER;
        if (nbytes == BYTES_THREE) begin
          r_nxt.code_rd   = 1'b1;
          r_nxt.code_addr = r.pc + 1'b1;
          r_nxt.st        = S_B3_WAIT;
        end
      end
      S_B3_WAIT: r_nxt.st = S_B3;
      S_B3: begin
        r_nxt.b3 = code_data;
        r_nxt.pc = r.pc + 1'b1;
        r_nxt.st = S_OPER;
      end
      S_OPER: begin
        r_nxt.st = S_OPR_WAIT;
        unique case (cls)
          CL_REG: begin
            r_nxt.reg_rd  = 1'b1;
            r_nxt.reg_sel = r.op[2:0];
          end
          CL_IND: begin
            r_nxt.reg_rd  = 1'b1;
            r_nxt.reg_sel = {2'b00, r.op[0]};
          end
          CL_DIR, CL_DIRIMM: begin
            r_nxt.dmem_rd   = 1'b1;
            r_nxt.dmem_addr = r.b2;
          end
          CL_BIT, CL_NBIT: begin
            r_nxt.bit_rd   = 1'b1;               // Read only; the bit is never written back
            r_nxt.bit_addr = r.b2;
          end
          default: r_nxt.st = S_EXEC;
        endcase
      end
      S_OPR_WAIT: r_nxt.st = (cls == CL_IND) ? S_PTR : S_EXEC;
      S_PTR: begin
        r_nxt.dmem_rd   = 1'b1;
        r_nxt.dmem_addr = reg_rdata;
        r_nxt.st        = S_PTR_WAIT;
      end
      S_PTR_WAIT: r_nxt.st = S_EXEC;
      S_EXEC: begin
        r_nxt.acc = acc_res;
        r_nxt.cy  = carry_res;
        if (cls == CL_JMP) begin
          r_nxt.pc = jump_pc;
        end
        if (cls == CL_DIRIMM) begin
          r_nxt.dmem_wr    = 1'b1;
          r_nxt.dmem_addr  = r.b2;
          r_nxt.dmem_wdata = mem_res;
        end
        r_nxt.done        = 1'b1;
        r_nxt.done_bytes  = nbytes;
        r_nxt.done_cycles = ncycles;
        r_nxt.unknown     = (cls == CL_NONE);
        r_nxt.st          = S_FETCH;
      end
      default: r_nxt.st = S_FETCH;
    endcase
  end

  // Length of an opcode still on the code bus, before it is registered
  function automatic logic [1:0] pjl_decode_bytes(input logic [7:0] o);
    logic [1:0] b;
    b = BYTES_ONE;
    if (o[4:0] == JMP_LOW_BITS || o == OP_AND_IMM || o == OP_AND_DIR || o == OP_AND_BIT || o == OP_AND_NBIT) begin
      b = BYTES_TWO;
    end else if (o == OP_AND_DIR_IMM) begin
      b = BYTES_THREE;
    end
    return b;
  endfunction

  // Reset loads whatever clk_en is; otherwise the whole state freezes while clk_en is low
  always_ff @(posedge core_clk) begin
    if (reset) begin
      r     <= '0;
      r.st  <= S_FETCH;
      r.pc  <= PC_RESET[PC_W-1:0];
      r.acc <= ACC_RESET;
      r.cy  <= CARRY_RESET;
    end else if (clk_en) begin
      r <= r_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign code_rd       = r.code_rd;
  assign code_addr     = r.code_addr;
  assign reg_rd        = r.reg_rd;
  assign reg_sel       = r.reg_sel;
  assign dmem_rd       = r.dmem_rd;
  assign dmem_wr       = r.dmem_wr;
  assign dmem_addr     = r.dmem_addr;
  assign dmem_wdata    = r.dmem_wdata;
  assign bit_rd        = r.bit_rd;
  assign bit_addr      = r.bit_addr;
  assign pc            = r.pc;
  assign acc           = r.acc;
  assign carry         = r.cy;
  assign instr_done    = r.done;
  assign instr_bytes   = r.done_bytes;
  assign instr_cycles  = r.done_cycles;
  assign instr_unknown = r.unknown;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  jump_target_a: assert property (
    (r.st == S_EXEC && cls == CL_JMP && clk_en) |=>
      pc == {$past(r.pc[PC_W-1:PAGE_LSB_W]), $past(r.op[7:5]), $past(r.b2)})
    else $error("page jump target wrong");

  jump_size_a: assert property (
    (r.st == S_OPC && clk_en && pjl_decode_bytes(code_data) == BYTES_TWO && code_data[4:0] == JMP_LOW_BITS) |=>
      code_rd && code_addr == pc && r.st == S_B2_WAIT)
    else $error("page jump second byte not fetched");

  and_imm_a: assert property (
    (r.st == S_EXEC && cls == CL_IMM && clk_en) |=> acc == ($past(r.acc) & $past(r.b2)) && instr_done)
    else $error("immediate AND result wrong");

  ind_pointer_a: assert property (
    (r.st == S_OPER && cls == CL_IND && clk_en) |=> reg_rd && reg_sel == {2'b00, $past(r.op[0])})
    else $error("indirect pointer select wrong");

  reg_select_a: assert property (
    (r.st == S_OPER && cls == CL_REG && clk_en) |=> reg_rd && reg_sel == $past(r.op[2:0]))
    else $error("working register select wrong");

  dir_address_a: assert property (
    (r.st == S_OPER && cls == CL_DIR && clk_en) |=> dmem_rd && dmem_addr == $past(r.b2) && !dmem_wr)
    else $error("direct address wrong");

  bit_carry_a: assert property (
    (r.st == S_EXEC && cls == CL_BIT && clk_en) |=> carry == ($past(r.cy) & $past(bit_rdata)))
    else $error("bit AND carry wrong");

  nbit_carry_a: assert property (
    (r.st == S_EXEC && cls == CL_NBIT && clk_en) |=>
      carry == ($past(r.cy) & ~$past(bit_rdata)) && !dmem_wr && instr_cycles == CYCLES_TWO)
    else $error("inverted bit AND carry wrong");

  dirimm_write_a: assert property (
    (r.st == S_EXEC && cls == CL_DIRIMM && clk_en) |=>
      dmem_wr && dmem_addr == $past(r.b2) && dmem_wdata == ($past(dmem_rdata) & $past(r.b3)))
    else $error("direct immediate write wrong");

  pc_advance_a: assert property (
    // Last fetched byte sits just below pc, page jump included
    (r.st == S_EXEC && clk_en) |-> r.pc == r.code_addr + PC_W'(1))
    else $error("program counter not past instruction");

endmodule

`default_nettype wire

// ===== rtl/pjl_pkg.sv
// Constants, opcodes and enumerations for the page jump and logical AND slice.
// Assumes a core that supplies code, register, data and bit storage through ports.
//
// Behaviour
// - Page jump replaces program counter bits 10..0
// - Target: opcode top 3 bits, second byte low
// - Upper bits from next instruction's address
// - Page jump: two bytes, two cycles, PC+2
// - 01010100 ANDs immediate byte into accumulator
// - 0101011r ANDs pointer-addressed memory into accumulator
// - Low opcode bit picks register zero or one
// - 01011rrr ANDs selected working register into accumulator
// - 01010101 ANDs direct address byte into accumulator
// - Direct addresses are 8 bits, 0 to 255
// - Bit AND: carry becomes carry AND bit
// - Bit address is second byte, 0 to 255
// - 10110000: carry becomes carry AND NOT bit
// - Inverted bit source stays unchanged in storage
// - Direct immediate AND writes result back to direct address
`default_nettype none

package pjl_pkg;

  // ****************************************
  // Opcodes and opcode patterns
  // ****************************************
  localparam logic [7:0] OP_AND_IMM     = 8'h54;
  localparam logic [7:0] OP_AND_DIR     = 8'h55;
  localparam logic [7:0] OP_AND_DIR_IMM = 8'h53;
  localparam logic [7:0] OP_AND_BIT     = 8'h82;
  localparam logic [7:0] OP_AND_NBIT    = 8'hb0;
  localparam logic [4:0] JMP_LOW_BITS   = 5'h01;
  localparam logic [6:0] IND_HIGH_BITS  = 7'h2b;
  localparam logic [4:0] REG_HIGH_BITS  = 5'h0b;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int PAGE_LSB_W  = 11;
  localparam int OP_PAGE_MSB = 7;
  localparam int OP_PAGE_LSB = 5;

  // ****************************************
  // Byte and machine cycle counts
  // ****************************************
  localparam logic [1:0] BYTES_ONE   = 2'h1;
  localparam logic [1:0] BYTES_TWO   = 2'h2;
  localparam logic [1:0] BYTES_THREE = 2'h3;
  localparam logic [1:0] CYCLES_ONE  = 2'h1;
  localparam logic [1:0] CYCLES_TWO  = 2'h2;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic [15:0] PC_RESET    = 16'h0000;
  // All ones, so that the first AND after reset shows in acc and carry
  localparam logic [7:0]  ACC_RESET   = 8'hff;
  localparam logic        CARRY_RESET = 1'b1;

  typedef enum logic [3:0] {
    CL_NONE   = 4'h0,
    CL_JMP    = 4'h1,
    CL_IMM    = 4'h2,
    CL_IND    = 4'h3,
    CL_REG    = 4'h4,
    CL_DIR    = 4'h5,
    CL_BIT    = 4'h6,
    CL_NBIT   = 4'h7,
    CL_DIRIMM = 4'h8
  } pjl_class_type;

  typedef enum logic [3:0] {
    S_FETCH    = 4'h0,
    S_OPC_WAIT = 4'h1,
    S_OPC      = 4'h2,
    S_B2_WAIT  = 4'h3,
    S_B2       = 4'h4,
    S_B3_WAIT  = 4'h5,
    S_B3       = 4'h6,
    S_OPER     = 4'h7,
    S_OPR_WAIT = 4'h8,
    S_PTR      = 4'h9,
    S_PTR_WAIT = 4'ha,
    S_EXEC     = 4'hb
  } pjl_fsm_type;

endpackage

`default_nettype wire

// ===== rtl/pjl_decode.sv
// Opcode classifier: instruction class, length in bytes and machine cycles.
// Assumes a stable opcode byte; purely combinational.
`default_nettype none

module pjl_decode
  import pjl_pkg::*;
(
  // Opcode in
  input  wire logic [7:0]    opcode,
  // Decoded class and sizes
  output pjl_class_type      op_class,
  output logic [1:0]         op_bytes,
  output logic [1:0]         op_cycles
);

  // ****************************************
  // Classification
  // ****************************************
  always_comb begin
    op_class  = CL_NONE;
    op_bytes  = BYTES_ONE;
    op_cycles = CYCLES_ONE;
    if (opcode[4:0] == JMP_LOW_BITS) begin
      op_class  = CL_JMP;
      op_bytes  = BYTES_TWO;
      op_cycles = CYCLES_TWO;
    end else if (opcode == OP_AND_IMM) begin
      op_class  = CL_IMM;
      op_bytes  = BYTES_TWO;
    end else if (opcode[7:1] == IND_HIGH_BITS) begin
      op_class  = CL_IND;
    end else if (opcode[7:3] == REG_HIGH_BITS) begin
      op_class  = CL_REG;
    end else if (opcode == OP_AND_DIR) begin
      op_class  = CL_DIR;
      op_bytes  = BYTES_TWO;
    end else if (opcode == OP_AND_BIT) begin
      op_class  = CL_BIT;
      op_bytes  = BYTES_TWO;
    end else if (opcode == OP_AND_NBIT) begin
      op_class  = CL_NBIT;
      op_bytes  = BYTES_TWO;
      op_cycles = CYCLES_TWO;
    end else if (opcode == OP_AND_DIR_IMM) begin
      op_class  = CL_DIRIMM;
      op_bytes  = BYTES_THREE;
      op_cycles = CYCLES_TWO;
    end
  end

endmodule

`default_nettype wire

// ===== rtl/pjl_logic.sv
// Result logic: AND results, carry results and page jump target.
// Assumes operands are valid in the execute cycle; purely combinational.
`default_nettype none

module pjl_logic
  import pjl_pkg::*;
#(
  parameter int PC_W = 16
)
(
  // Instruction
  input  wire pjl_class_type    op_class,
  input  wire logic [7:0]       opcode,
  input  wire logic [7:0]       byte2,
  input  wire logic [7:0]       byte3,
  // Current core state
  input  wire logic [PC_W-1:0]  pc,
  input  wire logic [7:0]       acc,
  input  wire logic             carry,
  // Fetched operands
  input  wire logic [7:0]       reg_rdata,
  input  wire logic [7:0]       dmem_rdata,
  input  wire logic             bit_rdata,
  // Results
  output logic [7:0]            acc_res,
  output logic                  carry_res,
  output logic [7:0]            mem_res,
  output logic [PC_W-1:0]       jump_pc
);

  logic [7:0] src;

  // ****************************************
  // Operand select and results
  // ****************************************
  always_comb begin
    unique case (op_class)
      CL_IMM:  src = byte2;
      CL_REG:  src = reg_rdata;
      default: src = dmem_rdata;
    endcase
    acc_res = acc;
    if (op_class == CL_IMM || op_class == CL_REG || op_class == CL_IND || op_class == CL_DIR) begin
      acc_res = acc & src;
    end
    carry_res = carry;
    if (op_class == CL_BIT) begin
      carry_res = carry & bit_rdata;
    end else if (op_class == CL_NBIT) begin
      carry_res = carry & ~bit_rdata;
    end
    mem_res = dmem_rdata & byte3;
    // Upper bits come from the already advanced pc
    jump_pc = {pc[PC_W-1:PAGE_LSB_W], opcode[OP_PAGE_MSB:OP_PAGE_LSB], byte2};
  end

endmodule

`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the page jump and logical AND sequencer.
// Assumes stores that answer one enabled cycle after a strobe; the bench plays them.
`default_nettype none

module tb
  import pjl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Design signals and store contents
  // ****************************************
  logic        core_clk, reset, clk_en, code_rd, reg_rd, dmem_rd, dmem_wr, bit_rd, bit_rdata;
  logic        carry, instr_done, instr_unknown, en_free;
  logic [15:0] code_addr, pc, pc_ref;
  logic [7:0]  code_data, reg_rdata, dmem_addr, dmem_wdata, dmem_rdata, bit_addr, acc, acc_ref;
  logic [2:0]  reg_sel;
  logic [1:0]  instr_bytes, instr_cycles;
  logic        carry_ref;
  logic [7:0]  cmem [0:65535];
  logic [7:0]  rmem [0:7];
  logic [7:0]  dmem [0:255];
  logic        bmem [0:255];
  logic [7:0]  last_da, last_ba;
  logic [2:0]  last_rs;
  int          n_code, n_reg, n_drd, n_bit, err_total, compares;

  pjl_core #(.PC_W(16)) DUT (
    .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .code_rd(code_rd), .code_addr(code_addr), .code_data(code_data),
    .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_rdata(reg_rdata),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata),
    .dmem_rdata(dmem_rdata), .bit_rd(bit_rd), .bit_addr(bit_addr), .bit_rdata(bit_rdata),
    .pc(pc), .acc(acc), .carry(carry), .instr_done(instr_done), .instr_bytes(instr_bytes),
    .instr_cycles(instr_cycles), .instr_unknown(instr_unknown)
  );

  always #2.5 core_clk = ~core_clk;

  // ****************************************
  // Store models
  // ****************************************
  // Strobes are read before the edge's updates land; idle read lines flip so stale data never matches
  always @(posedge core_clk) begin : stores
    logic        en, cr, rr, dr, dw, br;
    logic [15:0] ca;
    logic [2:0]  rs;
    logic [7:0]  da, dd, ba;
    en = clk_en; cr = code_rd; rr = reg_rd; dr = dmem_rd; dw = dmem_wr; br = bit_rd;
    ca = code_addr; rs = reg_sel; da = dmem_addr; dd = dmem_wdata; ba = bit_addr;
    #1;
    clk_en <= en_free ? (($urandom % 8) != 0) : 1'b1;
    if (en) begin
      code_data  <= cr ? cmem[ca] : ~code_data;
      reg_rdata  <= rr ? rmem[rs] : ~reg_rdata;
      dmem_rdata <= dr ? dmem[da] : ~dmem_rdata;
      bit_rdata  <= br ? bmem[ba] : ~bit_rdata;
      if (cr) begin
        check(ca, pc_ref + 16'(n_code));
        n_code++;
      end
      if (rr) begin n_reg++; last_rs = rs; end
      if (dr) begin n_drd++; last_da = da; end
      if (br) begin n_bit++; last_ba = ba; end
      if (dw) dmem[da] = dd;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h expected %h at pc %h", $time, seen, exp, pc_ref);
    end
  endtask

  // ****************************************
  // One instruction with its expectations
  // ****************************************
  // Acc and carry only lose bits here; tests reset often so the AND checks see ones
  task automatic do_op(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3);
    logic [15:0] nx;
    logic [1:0]  nb, nc;
    logic [7:0]  ea, ed, eda;
    logic        ec, unk, wr;
    int          er, edr, eb, n;
    nb = 2'h1; nc = 2'h1; unk = 1'b0; wr = 1'b0; ea = acc_ref; ec = carry_ref; ed = 8'h00;
    er = 0; edr = 0; eb = 0; eda = b2;
    cmem[pc_ref] = op;
    cmem[pc_ref + 16'h1] = b2;
    cmem[pc_ref + 16'h2] = b3;
    if (op[4:0] == 5'h01) begin nb = 2'h2; nc = 2'h2; end
    else if (op == 8'h54) begin nb = 2'h2; ea = acc_ref & b2; end
    else if (op[7:1] == 7'h2b) begin er = 1; edr = 1; eda = rmem[op[0]]; ea = acc_ref & dmem[eda]; end
    else if (op[7:3] == 5'h0b) begin er = 1; ea = acc_ref & rmem[op[2:0]]; end
    else if (op == 8'h55) begin nb = 2'h2; edr = 1; ea = acc_ref & dmem[b2]; end
    else if (op == OP_AND_BIT) begin nb = 2'h2; eb = 1; ec = carry_ref & bmem[b2]; end
    else if (op == 8'hb0) begin nb = 2'h2; nc = 2'h2; eb = 1; ec = carry_ref & ~bmem[b2]; end
    else if (op == 8'h53) begin nb = 2'h3; nc = 2'h2; edr = 1; wr = 1'b1; ed = dmem[b2] & b3; end
    else unk = 1'b1;
    nx = pc_ref + 16'(nb);
    if (op[4:0] == 5'h01) nx = {nx[15:11], op[7:5], b2};
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (!(instr_done === 1'b1 && clk_en === 1'b1) && n < 300);
    check(16'(n < 300), 16'h1);
    check(pc, nx);
    check(16'(acc), 16'(ea));
    check(16'(carry), 16'(ec));
    check(16'(instr_bytes), 16'(nb));
    check(16'(instr_cycles), 16'(nc));
    check(16'(instr_unknown), 16'(unk));
    check(16'(n_code), 16'(nb));
    check(16'(n_reg), 16'(er));
    check(16'(n_drd), 16'(edr));
    check(16'(n_bit), 16'(eb));
    if (er != 0) check(16'(last_rs), op[7:1] == 7'h2b ? 16'(op[0]) : 16'(op[2:0]));
    if (edr != 0) check(16'(last_da), 16'(eda));
    if (eb != 0) check(16'(last_ba), 16'(b2));
    check(16'(dmem_wr), 16'(wr));
    if (wr) check({dmem_addr, dmem_wdata}, {b2, ed});
    if (wr) dmem[b2] = ed;
    pc_ref = nx; acc_ref = ea; carry_ref = ec;
    n_code = 0; n_reg = 0; n_drd = 0; n_bit = 0;
  endtask

  function automatic logic [7:0] pick();
    case ($urandom % 10)
      0: pick = {3'($urandom), 5'h01};
      1: pick = 8'h54;
      2: pick = {7'h2b, 1'($urandom)};
      3: pick = {5'h0b, 3'($urandom)};
      4: pick = 8'h55;
      5: pick = OP_AND_BIT;
      6: pick = 8'hb0;
      7: pick = 8'h53;
      default: pick = 8'($urandom);
    endcase
  endfunction

  task automatic do_reset(input int cycles);
    en_free = 1'b0;
    @(posedge core_clk);
    #1;
    reset = 1'b1;
    repeat (cycles) @(posedge core_clk);
    @(negedge core_clk);
    check(pc, PC_RESET);
    check({acc, 7'h00, carry}, {ACC_RESET, 7'h00, CARRY_RESET});
    check(16'({code_rd, reg_rd, dmem_rd, dmem_wr, bit_rd, instr_done, instr_unknown}), 16'h0000);
    @(posedge core_clk);
    #1;
    reset = 1'b0;
    pc_ref = PC_RESET; acc_ref = ACC_RESET; carry_ref = CARRY_RESET;
    n_code = 0; n_reg = 0; n_drd = 0; n_bit = 0;
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    core_clk = 1'b0; reset = 1'b1; en_free = 1'b0;
    pc_ref = PC_RESET; acc_ref = ACC_RESET; carry_ref = CARRY_RESET;
    err_total = 0; compares = 0;
    void'($urandom(32'ha47941b2));
    for (int i = 0; i < 256; i++) begin dmem[i] = 8'($urandom); bmem[i] = 1'($urandom); end
    for (int i = 0; i < 8; i++) rmem[i] = 8'($urandom);
    bmem[0] = 1'b1;
    bmem[1] = 1'b0;
    do_reset(16);
    // A reset before each case refills acc and carry, which the ANDs only drain
    for (int i = 0; i < 8; i++) begin
      do_reset(2);
      do_op({5'h0b, 3'(i)}, 8'h00, 8'h00);
      if (i < 2) begin
        do_reset(2);
        do_op({7'h2b, 1'(i)}, 8'h00, 8'h00);
        do_reset(2);
        do_op(OP_AND_BIT, 8'(i), 8'h00);
        do_reset(2);
        do_op(8'hb0, 8'(i), 8'h00);
      end
    end
    do_reset(2);
    do_op(8'h54, 8'h5a, 8'h00);
    do_op(8'h54, 8'h0f, 8'h00);
    do_reset(2);
    do_op(8'h55, 8'hff, 8'h00);
    do_op(8'h53, 8'hff, 8'h5a);
    do_op(8'h55, 8'hff, 8'h00);
    do_op(8'h53, 8'h00, 8'hc3);
    do_op(8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 8; i++) do_op({3'(i), 5'h01}, 8'($urandom), 8'h00);
    $display("Test directed done");
    // Page walk: jump to the page's last two bytes, then cross into the next page
    en_free = 1'b1;
    for (int p = 0; p < 31; p++) begin
      do_op(8'he1, 8'hfe, 8'h00);
      do_op({3'($urandom), 5'h01}, 8'($urandom), 8'h00);
    end
    $display("Test page walk done");
    repeat (60) begin
      do_reset(2);
      en_free = 1'b1;
      repeat (6) do_op(pick(), 8'($urandom), 8'($urandom));
    end
    $display("Test random done");
    do_reset(3);
    en_free = 1'b1;
    repeat (100) do_op(pick(), 8'($urandom), 8'($urandom));
    $display("Test reset and random done");
    end_sim();
  end

  initial begin
    #200000;
    err_total++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    end_sim();
  end

endmodule

`default_nettype wire
